// *** design/wdtm_top.sv ***
// Watchdog timer with interrupt/reset modes and timed change protection
// Behaviour
// - Mode from fuse, reset enable, irq enable
// - Combined mode: first time-out flags; ack clears
// - Unserviced flag at next time-out resets system
// - Change enable self-clears after four cycles
// - Reset flag forces reset enable high
// - Change enable bit 4, reset enable bit 3
// - Prescale msb bit 5, low bits 2..0
// - Time-out 2048 doubling to 1048576 cycles
module wdtm_top #(
   parameter int BASE_CYCLES = wdtm_pkg::BASE_OSC_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wdog_osc,
   input wire logic watchdog_always_on_fuse,
   input wire logic wdog_restart,
   input wire logic wdog_irq_ack,
   output logic wdog_irq_req,
   output logic sys_reset_req,
   output logic irq
);
   localparam int CW = wdtm_pkg::COUNT_W;
   localparam int SW = wdtm_pkg::STAT_W;
   localparam int PRE_LO_W_C = wdtm_pkg::PRE_LO_W;

   // --------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------
   logic osc_s, fuse_s, osc_prev_q, tick;

   wdtm_sync #(.W(2)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({wdog_osc, watchdog_always_on_fuse}),
      .q({osc_s, fuse_s})
   );

   // Previous level resets to the pin's idle low: no false edge
   assign tick = osc_s & ~osc_prev_q;

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   logic rst_en_q, rst_en_d;
   logic ie_q, ie_d;
   logic flag_q, flag_d;
   logic ce_q, ce_d;
   logic [2:0] ce_cnt_q, ce_cnt_d;
   logic [3:0] pre_q, pre_d;
   logic rst_flag_q, rst_flag_d;
   logic [SW-1:0] stat_q, stat_d;
   logic [SW-1:0] mask_q, mask_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic sys_reset_q, sys_reset_d;
   logic irq_q, irq_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic irq_req_q, irq_req_d;

   // --------------------------------------------------------------
   // Bus decode
   // --------------------------------------------------------------
   logic setup, wr, wr_ctrl, ce_wr, mapped;
   logic to, do_reset, do_flag;

   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite & pready_q;
   assign wr_ctrl = wr & (paddr == wdtm_pkg::ADDR_CTRL);
   assign ce_wr = wr_ctrl & pwdata[wdtm_pkg::CTRL_CHG_EN];
   // Registers fill every word from zero up to the counter
   assign mapped = (paddr[1:0] == 2'h0) && (paddr <= wdtm_pkg::ADDR_COUNT);

   // --------------------------------------------------------------
   // Mode and time-out
   // --------------------------------------------------------------
   wdtm_pkg::wdtm_mode_t mode;
   logic [3:0] code_c;
   logic [CW-1:0] limit;

   always_comb begin
      if (fuse_s) begin
         mode = wdtm_pkg::MODE_RST;
      end else begin
         case ({rst_en_q, ie_q})
            2'b01: mode = wdtm_pkg::MODE_IRQ;
            2'b10: mode = wdtm_pkg::MODE_RST;
            2'b11: mode = wdtm_pkg::MODE_IRQ_RST;
            default: mode = wdtm_pkg::MODE_STOP;
         endcase
      end
      // Reserved codes run at the longest period rather than stall
      code_c = (pre_q > wdtm_pkg::PRE_MAX_CODE) ?
               wdtm_pkg::PRE_MAX_CODE : pre_q;
      limit = CW'(BASE_CYCLES) << code_c;
      to = tick & (cnt_q == limit - CW'(1)) &
           (mode != wdtm_pkg::MODE_STOP);
   end

   // --------------------------------------------------------------
   // Next-state logic
   // --------------------------------------------------------------
   always_comb begin
      rst_en_d = rst_en_q;
      ie_d = ie_q;
      flag_d = flag_q;
      ce_d = ce_q;
      ce_cnt_d = ce_cnt_q;
      pre_d = pre_q;
      rst_flag_d = rst_flag_q;
      stat_d = stat_q;
      mask_d = mask_q;
      cnt_d = cnt_q;
      do_reset = 1'b0;
      do_flag = 1'b0;
      // Change window closes on its own
      if (ce_q) begin
         ce_cnt_d = ce_cnt_q - 3'h1;
         if (ce_cnt_q == 3'h1) begin
            ce_d = 1'b0;
         end
      end
      if (wr_ctrl) begin
         ie_d = pwdata[wdtm_pkg::CTRL_IRQ_EN];
         if (pwdata[wdtm_pkg::CTRL_IRQ_FLAG]) begin
            flag_d = 1'b0;
         end
         if (ce_q) begin
            rst_en_d = pwdata[wdtm_pkg::CTRL_RST_EN];
            pre_d = {pwdata[wdtm_pkg::CTRL_PRE_MSB],
                     pwdata[wdtm_pkg::CTRL_PRE_LO +: PRE_LO_W_C]};
         end else begin
            // Outside the window the reset enable can only be raised
            rst_en_d = rst_en_q | pwdata[wdtm_pkg::CTRL_RST_EN];
         end
         if (pwdata[wdtm_pkg::CTRL_CHG_EN]) begin
            ce_d = 1'b1;
            ce_cnt_d = wdtm_pkg::CE_HOLD_CYCLES;
         end
      end
      if (wr && paddr == wdtm_pkg::ADDR_CAUSE &&
          pwdata[wdtm_pkg::CAUSE_WDOG_RST]) begin
         rst_flag_d = 1'b0;
      end
      if (wr && paddr == wdtm_pkg::ADDR_STAT) begin
         stat_d = stat_q & ~pwdata[SW-1:0];
      end
      if (wr && paddr == wdtm_pkg::ADDR_MASK) begin
         mask_d = pwdata[SW-1:0];
      end
      // Vector taken: flag drops, and in combined mode so does the enable
      if (wdog_irq_ack && flag_q) begin
         flag_d = 1'b0;
         if (rst_en_q) begin
            ie_d = 1'b0;
         end
      end
      if (to) begin
         case (mode)
            wdtm_pkg::MODE_IRQ: do_flag = 1'b1;
            wdtm_pkg::MODE_RST: do_reset = 1'b1;
            wdtm_pkg::MODE_IRQ_RST: begin
               if (flag_q) begin
                  do_reset = 1'b1;
               end else begin
                  do_flag = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // Hardware sets win over software clears
      if (do_flag) begin
         flag_d = 1'b1;
         stat_d[wdtm_pkg::STAT_TIMEOUT] = 1'b1;
      end
      if (do_reset) begin
         rst_flag_d = 1'b1;
         stat_d[wdtm_pkg::STAT_RESET] = 1'b1;
      end
      if (rst_flag_d) begin
         rst_en_d = 1'b1;
      end
      if (wdog_restart || to || mode == wdtm_pkg::MODE_STOP) begin
         cnt_d = '0;
      end else if (tick) begin
         cnt_d = cnt_q + CW'(1);
      end
   end

   // --------------------------------------------------------------
   // APB answer and outputs
   // --------------------------------------------------------------
   always_comb begin
      prdata_d = 32'h0000_0000;
      pready_d = setup;
      pslverr_d = setup & ~mapped;
      sys_reset_d = do_reset;
      irq_d = |(stat_d & mask_d);
      irq_req_d = flag_d & ie_d;
      if (setup && !pwrite) begin
         case (paddr)
            wdtm_pkg::ADDR_CTRL: begin
               prdata_d[wdtm_pkg::CTRL_IRQ_FLAG] = flag_q;
               prdata_d[wdtm_pkg::CTRL_IRQ_EN] = ie_q;
               prdata_d[wdtm_pkg::CTRL_PRE_MSB] = pre_q[3];
               prdata_d[wdtm_pkg::CTRL_CHG_EN] = ce_q;
               prdata_d[wdtm_pkg::CTRL_RST_EN] = rst_en_q;
               prdata_d[wdtm_pkg::CTRL_PRE_LO +: PRE_LO_W_C] =
                  pre_q[2:0];
            end
            wdtm_pkg::ADDR_CAUSE:
               prdata_d[wdtm_pkg::CAUSE_WDOG_RST] = rst_flag_q;
            wdtm_pkg::ADDR_STAT: prdata_d[SW-1:0] = stat_q;
            wdtm_pkg::ADDR_MASK: prdata_d[SW-1:0] = mask_q;
            wdtm_pkg::ADDR_COUNT: prdata_d[CW-1:0] = cnt_q;
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_en_q <= wdtm_pkg::RST_EN_RESET;
         ie_q <= wdtm_pkg::IRQ_EN_RESET;
         flag_q <= 1'b0;
         ce_q <= 1'b0;
         ce_cnt_q <= 3'h0;
         pre_q <= wdtm_pkg::PRE_RESET;
         rst_flag_q <= 1'b0;
         stat_q <= wdtm_pkg::STAT_RESET_VAL;
         mask_q <= wdtm_pkg::MASK_RESET_VAL;
         cnt_q <= '0;
         sys_reset_q <= 1'b0;
         irq_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_req_q <= 1'b0;
         osc_prev_q <= 1'b0;
      end else begin
         rst_en_q <= rst_en_d;
         ie_q <= ie_d;
         flag_q <= flag_d;
         ce_q <= ce_d;
         ce_cnt_q <= ce_cnt_d;
         pre_q <= pre_d;
         rst_flag_q <= rst_flag_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         cnt_q <= cnt_d;
         sys_reset_q <= sys_reset_d;
         irq_q <= irq_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         irq_req_q <= irq_req_d;
         osc_prev_q <= osc_s;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign wdog_irq_req = irq_req_q;
   assign sys_reset_req = sys_reset_q;
   assign irq = irq_q;

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_ce_open;
      $rose(ce_q) ##0 (!ce_wr) [*4];
   endsequence
   sequence s_ce_closed;
      !ce_q && ce_cnt_q == 3'h0;
   endsequence
   chk_stop_idle: assert property (
      (!fuse_s && !rst_en_q && !ie_q) |=> cnt_q == '0 && !sys_reset_q)
      else $error("stopped watchdog counted or reset");
   chk_irq_mode_flag: assert property (
      (to && mode == wdtm_pkg::MODE_IRQ) |=> flag_q && !sys_reset_q)
      else $error("interrupt mode time-out wrong");
   chk_first_to_flag: assert property (
      (to && mode == wdtm_pkg::MODE_IRQ_RST && !flag_q)
      |=> flag_q && !sys_reset_q ##1 !sys_reset_q)
      else $error("first combined time-out did not flag");
   chk_ack_clears: assert property (
      (wdog_irq_ack && flag_q && rst_en_q && !to && !wr_ctrl)
      |=> !flag_q && !ie_q && rst_en_q)
      else $error("vector ack did not clear flag and enable");
   chk_second_to_rst: assert property (
      (to && mode == wdtm_pkg::MODE_IRQ_RST && flag_q)
      |=> sys_reset_q && rst_flag_q ##1 !sys_reset_q)
      else $error("unserviced time-out did not reset");
   chk_ce_hold: assert property (
      s_ce_open |=> s_ce_closed)
      else $error("change enable not cleared after four cycles");
   chk_ce_four: assert property (
      $rose(ce_q) |-> ce_q [*4])
      else $error("change enable dropped early");
   chk_flag_forces_en: assert property (
      rst_flag_q |-> rst_en_q)
      else $error("reset enable low while reset flag set");
   chk_pre_locked: assert property (
      (wr_ctrl && !ce_q) |=> $stable(pre_q) && rst_en_q >= $past(rst_en_q))
      else $error("protected setting changed without window");
   chk_ctrl_fields: assert property (
      (setup && !pwrite && paddr == wdtm_pkg::ADDR_CTRL) |=>
      prdata_q[4] == $past(ce_q) && prdata_q[3] == $past(rst_en_q))
      else $error("control bits 4 and 3 misplaced");
   chk_pre_fields: assert property (
      (setup && !pwrite && paddr == wdtm_pkg::ADDR_CTRL) |=>
      {prdata_q[5], prdata_q[2:0]} == $past(pre_q))
      else $error("prescale field misplaced");
   chk_to_count: assert property (
      to |-> cnt_q == (CW'(BASE_CYCLES) << code_c) - CW'(1))
      else $error("time-out at wrong count");
   chk_restart: assert property (
      (wdog_restart || to) |=> cnt_q == '0)
      else $error("counter not restarted");
endmodule

// *** design/wdtm_pkg.sv ***
// Package: register map, field positions and timing constants of the watchdog
package wdtm_pkg;
   // --------------------------------------------------------------
   // Register byte offsets
   // --------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CAUSE = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0C;
   localparam logic [7:0] ADDR_COUNT = 8'h10;
   // --------------------------------------------------------------
   // Control register fields
   // --------------------------------------------------------------
   localparam int CTRL_IRQ_FLAG = 7;
   localparam int CTRL_IRQ_EN = 6;
   localparam int CTRL_PRE_MSB = 5;
   localparam int CTRL_CHG_EN = 4;
   localparam int CTRL_RST_EN = 3;
   localparam int CTRL_PRE_LO = 0;
   localparam int PRE_LO_W = 3;
   // --------------------------------------------------------------
   // Reset cause, status and mask fields
   // --------------------------------------------------------------
   localparam int CAUSE_WDOG_RST = 3;
   localparam int STAT_TIMEOUT = 0;
   localparam int STAT_RESET = 1;
   localparam int STAT_W = 2;
   // --------------------------------------------------------------
   // Reset values and timing
   // --------------------------------------------------------------
   localparam logic RST_EN_RESET = 1'b0;
   localparam logic IRQ_EN_RESET = 1'b0;
   localparam logic [3:0] PRE_RESET = 4'h0;
   localparam logic [STAT_W-1:0] STAT_RESET_VAL = 2'h0;
   localparam logic [STAT_W-1:0] MASK_RESET_VAL = 2'h0;
   localparam logic [2:0] CE_HOLD_CYCLES = 3'h4;
   localparam logic [3:0] PRE_MAX_CODE = 4'h9;
   localparam int BASE_OSC_CYCLES = 2048;
   localparam int COUNT_W = 21;
   // --------------------------------------------------------------
   // Time-out modes
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_STOP,
      MODE_IRQ,
      MODE_RST,
      MODE_IRQ_RST
   } wdtm_mode_t;
endpackage

// *** design/wdtm_sync.sv ***
// Two-stage synchroniser for inputs arriving from outside pclk
module wdtm_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// *** bench/tb_watchdog_timer_modes.sv ***
// Self-checking bench for the watchdog timer with interrupt/reset modes
module tb_watchdog_timer_modes;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // Signals and design instance
   // ------------------------------------------------------------
   localparam int BASE = 4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic wdog_osc, fuse, wdog_restart, wdog_irq_ack;
   logic wdog_irq_req, sys_reset_req, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int fails, num_checks, cyc, n_rst, n0, per, k;
   logic [7:0] ctl [7];
   logic fz [7];
   int er [7];
   int ef [7];

   wdtm_top #(.BASE_CYCLES(BASE)) u_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wdog_osc(wdog_osc), .watchdog_always_on_fuse(fuse),
      .wdog_restart(wdog_restart), .wdog_irq_ack(wdog_irq_ack),
      .wdog_irq_req(wdog_irq_req), .sys_reset_req(sys_reset_req),
      .irq(irq)
   );

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Reset pulses counted here so checks never race the one-cycle pulse
   always @(posedge pclk) begin
      cyc++;
      if (sys_reset_req === 1'b1) n_rst <= n_rst + 1;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task end_sim;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Protected fields need the window opened by a separate write
   task automatic ctrl_prot(input logic [31:0] v);
      apb(1'b1, wdtm_pkg::ADDR_CTRL, 32'h10);
      apb(1'b1, wdtm_pkg::ADDR_CTRL, v);
   endtask

   task automatic pulse(input int which);
      @(posedge pclk);
      if (which == 0) wdog_restart <= 1'b1;
      else wdog_irq_ack <= 1'b1;
      @(posedge pclk);
      wdog_restart <= 1'b0;
      wdog_irq_ack <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   // Each tick is one rising edge of the slow oscillator
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         wdog_osc <= 1'b1;
         repeat (3) @(posedge pclk);
         wdog_osc <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, wdog_osc, fuse} = '0;
      {wdog_restart, wdog_irq_ack} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      ctl = '{8'h00, 8'h40, 8'h08, 8'h00, 8'h09, 8'h0A, 8'h48};
      fz = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      er = '{0, 0, 1, 1, 1, 1, 0};
      ef = '{0, 1, 0, 0, 0, 0, 1};
      void'($urandom(60962));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 5; a++) begin
         apb(1'b0, 8'(4 * a), 32'h0);
         chk("reset value", rd, 32'h0);
         chk("mapped err", {31'h0, err}, 32'h0);
      end
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped err", {31'h0, err}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      // Window opens, then closes by itself
      apb(1'b1, wdtm_pkg::ADDR_CTRL, 32'h10);
      apb(1'b0, wdtm_pkg::ADDR_CTRL, 32'h0);
      chk("ce open", rd, 32'h10);
      repeat (2) @(posedge pclk);
      apb(1'b0, wdtm_pkg::ADDR_CTRL, 32'h0);
      chk("ce closed", rd, 32'h0);
      apb(1'b1, wdtm_pkg::ADDR_CTRL, 32'h2F);
      apb(1'b0, wdtm_pkg::ADDR_CTRL, 32'h0);
      chk("unprotected", rd, 32'h08);
      apb(1'b1, wdtm_pkg::ADDR_CTRL, 32'h00);
      apb(1'b0, wdtm_pkg::ADDR_CTRL, 32'h0);
      chk("clear refused", rd, 32'h08);
      k = $urandom_range(0, 15);
      ctrl_prot(32'h08 | ((k & 8) << 2) | (k & 7));
      apb(1'b0, wdtm_pkg::ADDR_CTRL, 32'h0);
      chk("field layout", rd, 32'h08 | ((k & 8) << 2) | (k & 7));
      ctrl_prot(32'h0);
      apb(1'b0, wdtm_pkg::ADDR_CTRL, 32'h0);
      chk("cleared in window", rd, 32'h0);
      // Mode and period table
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, wdtm_pkg::ADDR_CAUSE, 32'h08);
         ctrl_prot(32'h80 | 32'(ctl[i]));
         fuse <= fz[i];
         per = BASE << ctl[i][2:0];
         pulse(0);
         k = $urandom_range(0, per - 1);
         ticks(k);
         pulse(0);
         n0 = n_rst;
         ticks(per - 1);
         chk("early reset", n_rst - n0, 0);
         ticks(1);
         chk("reset count", n_rst - n0, er[i]);
         apb(1'b0, wdtm_pkg::ADDR_CTRL, 32'h0);
         chk("flag", 32'(rd[7]), ef[i]);
         chk("irq req", 32'(wdog_irq_req), ef[i]);
         fuse <= 1'b0;
      end
      // Combined mode: ack, re-arm, then an unserviced time-out
      pulse(1);
      apb(1'b0, wdtm_pkg::ADDR_CTRL, 32'h0);
      chk("ack clears", rd, 32'h08);
      apb(1'b1, wdtm_pkg::ADDR_CTRL, 32'h48);
      pulse(0);
      n0 = n_rst;
      ticks(BASE);
      apb(1'b0, wdtm_pkg::ADDR_CTRL, 32'h0);
      chk("first flag", rd, 32'hC8);
      chk("no reset yet", n_rst - n0, 0);
      ticks(BASE);
      chk("unserviced", n_rst - n0, 1);
      apb(1'b0, wdtm_pkg::ADDR_CAUSE, 32'h0);
      chk("cause flag", rd, 32'h08);
      ctrl_prot(32'h0);
      apb(1'b0, wdtm_pkg::ADDR_CTRL, 32'h0);
      chk("forced enable", 32'(rd[3]), 1);
      apb(1'b1, wdtm_pkg::ADDR_CAUSE, 32'h08);
      ctrl_prot(32'h80);
      apb(1'b0, wdtm_pkg::ADDR_CTRL, 32'h0);
      chk("enable freed", rd, 32'h0);
      // Status, mask and interrupt line
      apb(1'b0, wdtm_pkg::ADDR_STAT, 32'h0);
      chk("events", rd, 32'h3);
      chk("irq masked", 32'(irq), 0);
      apb(1'b1, wdtm_pkg::ADDR_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq on", 32'(irq), 1);
      apb(1'b1, wdtm_pkg::ADDR_STAT, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq off", 32'(irq), 0);
      apb(1'b1, wdtm_pkg::ADDR_MASK, 32'h2);
      repeat (2) @(posedge pclk);
      chk("irq reset event", 32'(irq), 1);
      apb(1'b1, wdtm_pkg::ADDR_STAT, 32'h2);
      apb(1'b0, wdtm_pkg::ADDR_STAT, 32'h0);
      chk("stat cleared", rd, 32'h0);
      apb(1'b0, wdtm_pkg::ADDR_MASK, 32'h0);
      chk("mask value", rd, 32'h2);
      chk("irq cleared", 32'(irq), 0);
      end_sim();
   end
endmodule
